// ==== hdl/irq_ctrl_pkg.sv ====
// Package: constants and carrier types of the interrupt entry/exit control
package irq_ctrl_pkg;
  // Register port offsets
  localparam logic [3:0] OFS_CONTROL  = 4'h0;  // Global and group enables
  localparam logic [3:0] OFS_ENABLE   = 4'h1;  // Per-source enables
  localparam logic [3:0] OFS_FLAGS    = 4'h2;  // Sticky flags (read only)
  localparam logic [3:0] OFS_CLEAR    = 4'h3;  // Write one to clear flag
  localparam logic [3:0] OFS_GROUPMAP = 4'h4;  // 1 = source in peripheral group
  localparam logic [3:0] OFS_STATE    = 4'h5;  // Entry machine state
  // Field positions inside the control register
  localparam int CTL_GIE_BIT  = 7;             // Global enable bit
  localparam int CTL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT = 6;             // Peripheral group enable bit
  // Reset values
  localparam logic [7:0] RST_ENABLE   = 8'h00; // All sources disabled
  localparam logic [7:0] RST_GROUPMAP = 8'hfe; // Source 0 core, rest peripheral
  // Fixed vector and phase timing
  localparam logic [15:0] IRQ_VECTOR  = 16'h0004; // Interrupt vector address
  localparam logic [1:0]  PHASE_Q1    = 2'h0;     // First quarter-phase code
  localparam int          PC_W        = 16;       // Program counter width
  localparam int          CTX_W       = 32;       // Saved context width

  // Entry sequence states, one-hot
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,  // Running normally
    ST_WAIT  = 3'b010,  // Accepted, waiting for instruction end
    ST_ENTER = 3'b100   // Performing the vector jump
  } entry_state_t;

  // Requests from software to the register port
  typedef struct packed {
    logic [3:0] addr;   // Register offset
    logic [7:0] wdata;  // Write data
    logic       wr;     // Write strobe
    logic       rd;     // Read strobe
  } reg_req_t;

  // Core-side handshake into the controller
  typedef struct packed {
    logic [1:0]      phase;     // Quarter-phase counter of the core
    logic            instr_end; // Current instruction retires this cycle
    logic            return_from_irq_instruction;    // Return-from-irq instruction executes
    logic [PC_W-1:0] pc;        // Current program counter
    logic [CTX_W-1:0] ctx;      // Live critical core registers
  } core_in_t;

  // Commands to the core
  typedef struct packed {
    logic             flush;     // Discard the prefetched instruction
    logic             push;      // Push push_pc onto the return stack
    logic [PC_W-1:0]  push_pc;   // Value pushed
    logic             load_pc;   // Load new_pc into the program counter
    logic [PC_W-1:0]  new_pc;    // Vector address
    logic             pop;       // Pop the return stack into the PC
    logic             restore;   // Write shadow back into core registers
    logic [CTX_W-1:0] shadow;    // Saved context
  } core_out_t;
endpackage

// ==== hdl/irq_entry_exit_ctrl.sv ====
// Interrupt flag, enable and entry/exit sequencing for the core
`timescale 1ns/1ps
module irq_entry_exit_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter int N_SRC = 8                       // Number of sources
) (
  input  wire logic                 clk_sys_in,   // Instruction clock
  input  wire logic                 rst_n_in,     // Async reset, low
  input  wire logic [N_SRC-1:0]     event_in,     // Source event pulses
  input  wire irq_ctrl_pkg::reg_req_t  reg_in,    // Register port request
  output logic      [7:0]           rdata_out,    // Read data, next cycle
  input  wire irq_ctrl_pkg::core_in_t  core_in,   // Core status
  output irq_ctrl_pkg::core_out_t   core_out,     // Commands to the core
  output logic                      irq_out       // Enabled flag pending
);
  import irq_ctrl_pkg::*;

  // Whole module state
  typedef struct packed {
    logic             global_irq_enable;      // Global enable
    logic             peripheral_group_irq_enable;     // Peripheral group enable
    logic [N_SRC-1:0] en;       // Per-source enable
    logic [N_SRC-1:0] grp;      // Source belongs to peripheral group
    logic [N_SRC-1:0] flags;    // Sticky flags
    entry_state_t     st;       // Entry sequence state
    logic [7:0]       rdata;    // Read data register
    core_out_t        co;       // Registered core commands
    logic [CTX_W-1:0] shadow;   // Shadow copy of context
  } state_t;

  state_t r;       // Current state
  state_t next_r;  // Next state

  // Enabled pending request of the flags given
  function automatic logic pending(input logic [N_SRC-1:0] f,
                                   input logic [N_SRC-1:0] e,
                                   input logic [N_SRC-1:0] g,
                                   input logic             pe);
    pending = |(f & e & (~g | {N_SRC{pe}}));
  endfunction

  // Read mux of the register port
  function automatic logic [7:0] read_reg(input state_t s,
                                          input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      OFS_CONTROL: begin
        v[CTL_GIE_BIT]  = s.global_irq_enable;
        v[CTL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT] = s.peripheral_group_irq_enable;
      end
      OFS_ENABLE:   v = 8'(s.en);
      OFS_FLAGS:    v = 8'(s.flags);     // Polled by software
      OFS_GROUPMAP: v = 8'(s.grp);
      OFS_STATE:    v = 8'(s.st);
      default:      v = 8'h00;           // Unmapped and write-only read 0
    endcase
    read_reg = v;
  endfunction

  logic req;  // Request seen by the core
  assign req = pending(r.flags, r.en, r.grp, r.peripheral_group_irq_enable);

  // Next-state logic
  always_comb begin
    next_r = r;
    next_r.co.flush   = 1'b0;
    next_r.co.push    = 1'b0;
    next_r.co.load_pc = 1'b0;
    next_r.co.pop     = 1'b0;
    next_r.co.restore = 1'b0;
    next_r.rdata      = 8'h00;
    // Register reads answered one cycle later
    if (reg_in.rd) begin
      next_r.rdata = read_reg(r, reg_in.addr);
    end
    // Register writes; software clears flags before return
    if (reg_in.wr) begin
      unique case (reg_in.addr)
        OFS_CONTROL: begin
          next_r.global_irq_enable  = reg_in.wdata[CTL_GIE_BIT];
          next_r.peripheral_group_irq_enable = reg_in.wdata[CTL_PERIPHERAL_GROUP_IRQ_ENABLE_BIT];
        end
        OFS_ENABLE:   next_r.en    = reg_in.wdata[N_SRC-1:0];
        OFS_CLEAR:    next_r.flags = r.flags & ~reg_in.wdata[N_SRC-1:0];
        OFS_GROUPMAP: next_r.grp   = reg_in.wdata[N_SRC-1:0];
        default: ;
      endcase
    end
    // Events set flags regardless of enables; set beats clear
    next_r.flags = next_r.flags | event_in;
    // Entry sequence
    unique case (r.st)
      ST_RUN: begin
        // Sample only in the first quarter-phase
        // Held while global enable clear
        if (core_in.phase == PHASE_Q1 && r.global_irq_enable && req) begin
          next_r.global_irq_enable    = 1'b0;
          next_r.co.flush = 1'b1;
          next_r.st     = ST_WAIT;
        end else if (core_in.return_from_irq_instruction) begin
          next_r.co.pop     = 1'b1;
          next_r.co.restore = 1'b1;
          next_r.global_irq_enable        = 1'b1;
        end
      end
      ST_WAIT: begin
        // Latency follows the instruction in progress
        if (core_in.instr_end) begin
          next_r.st = ST_ENTER;
        end
      end
      ST_ENTER: begin
        next_r.co.push    = 1'b1;
        next_r.co.push_pc = core_in.pc;
        next_r.shadow     = core_in.ctx;
        next_r.co.load_pc = 1'b1;
        next_r.co.new_pc  = IRQ_VECTOR;
        next_r.st         = ST_RUN;
      end
      default: next_r.st = ST_RUN;
    endcase
    next_r.co.shadow = next_r.shadow;
  end

  // State register; every reset clears all enables
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r       <= '0;
      r.global_irq_enable   <= 1'b0;
      r.peripheral_group_irq_enable  <= 1'b0;
      r.en    <= N_SRC'(RST_ENABLE);
      r.grp   <= N_SRC'(RST_GROUPMAP);
      r.st    <= ST_RUN;
    end else begin
      r <= next_r;
    end
  end

  // Outputs
  assign rdata_out = r.rdata;
  assign core_out  = r.co;
  assign irq_out   = req & r.global_irq_enable;

  // Acceptance in Q1 clears global enable and flushes
  property p_accept;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st == ST_RUN && core_in.phase == PHASE_Q1 && r.global_irq_enable && req)
        |=> (!r.global_irq_enable && r.co.flush && r.st == ST_WAIT);
  endproperty
  a_accept: assert property (p_accept) else $error("accept wrong");

  // No acceptance outside Q1
  property p_q1_only;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st == ST_RUN && core_in.phase != PHASE_Q1)
        |=> (r.st != ST_WAIT);
  endproperty
  a_q1_only: assert property (p_q1_only) else $error("q1 only");

  // An event on source 0 always sets its flag
  property p_flag_set;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      event_in[0] |=> r.flags[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("lost");

  // Vector jump with push, then back to run
  sequence s_enter;
    r.st == ST_ENTER;
  endsequence
  property p_vector;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_enter |=> (r.co.load_pc && r.co.new_pc == IRQ_VECTOR
                   && r.co.push && r.st == ST_RUN);
  endproperty
  a_vector: assert property (p_vector) else $error("vector wrong");

  // Pushed counter equals counter at entry
  property p_push;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_enter |=> (r.co.push_pc == $past(core_in.pc));
  endproperty
  a_push: assert property (p_push) else $error("push pc wrong");

  // Shadow holds context at entry
  property p_shadow;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_enter |=> (r.shadow == $past(core_in.ctx));
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow wrong");

  // Return pops, restores and sets global enable
  property p_return;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st == ST_RUN && core_in.return_from_irq_instruction &&
       !(core_in.phase == PHASE_Q1 && r.global_irq_enable && req))
        |=> (r.co.pop && r.co.restore && r.global_irq_enable);
  endproperty
  a_return: assert property (p_return) else $error("return wrong");

  // Group sources need the group enable
  property p_group;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (!r.peripheral_group_irq_enable && ((r.flags & r.en & ~r.grp) == '0)) |-> !irq_out;
  endproperty
  a_group: assert property (p_group) else $error("group leak");

  // Wait state holds until the instruction ends
  property p_wait;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st == ST_WAIT && !core_in.instr_end) |=> (r.st == ST_WAIT);
  endproperty
  a_wait: assert property (p_wait) else $error("early entry");

  // Global enable clear blocks acceptance
  property p_gie_block;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st == ST_RUN && !r.global_irq_enable) |=> (r.st == ST_RUN);
  endproperty
  a_gie_block: assert property (p_gie_block) else $error("taken");

  // Enables read cleared at the first edge out of reset
  property p_rst_enables;
    @(posedge clk_sys_in)
      $rose(rst_n_in) |-> (r.en == '0 && !r.global_irq_enable && !r.peripheral_group_irq_enable);
  endproperty
  a_rst_enables: assert property (p_rst_enables) else $error("rst en");

  // A clear write without an event drops the flag
  sequence s_clear0;
    reg_in.wr && reg_in.addr == OFS_CLEAR && reg_in.wdata[0];
  endsequence
  property p_clear;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (s_clear0 and !event_in[0]) |=> !r.flags[0];
  endproperty
  a_clear: assert property (p_clear) else $error("clear lost");

  // A set flag stays set until it is cleared
  property p_flag_hold;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.flags[0] && !(reg_in.wr && reg_in.addr == OFS_CLEAR
                       && reg_in.wdata[0])) |=> r.flags[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag drop");

  // Interrupt level is low while the global enable is clear
  property p_irq_gie;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !r.global_irq_enable |-> !irq_out;
  endproperty
  a_irq_gie: assert property (p_irq_gie) else $error("irq on");

  // Flush is a single-cycle pulse
  property p_flush_pulse;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      r.co.flush |=> !r.co.flush;
  endproperty
  a_flush_pulse: assert property (p_flush_pulse) else $error("flush");

  // Instruction end in the wait state moves on to entry
  property p_enter_next;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st == ST_WAIT && core_in.instr_end) |=> (r.st == ST_ENTER);
  endproperty
  a_enter_next: assert property (p_enter_next) else $error("stuck");

  // The vector is loaded only out of the entry state
  property p_load_src;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      r.co.load_pc |-> ($past(r.st) == ST_ENTER);
  endproperty
  a_load_src: assert property (p_load_src) else $error("stray load");

  // No pop while the entry sequence runs
  property p_no_pop;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.st != ST_RUN) |=> !r.co.pop;
  endproperty
  a_no_pop: assert property (p_no_pop) else $error("pop busy");

  // A pop always follows a return instruction
  property p_pop_src;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      r.co.pop |-> $past(core_in.return_from_irq_instruction);
  endproperty
  a_pop_src: assert property (p_pop_src) else $error("stray pop");

  // Enabled group source with both enables raises the level
  property p_group_on;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (r.peripheral_group_irq_enable && r.global_irq_enable && r.flags[1] && r.en[1]) |-> irq_out;
  endproperty
  a_group_on: assert property (p_group_on) else $error("no irq");
endmodule // irq_entry_exit_ctrl

// ==== sim/core_model.sv ====
// Behavioural core: phase count, pc, context and one-deep return stack
`timescale 1ns/1ps
module core_model
  import irq_ctrl_pkg::*;
(
  input  wire logic                clk_sys_in, // Instruction clock
  input  wire logic                rst_n_in,   // Async reset, low
  input  wire logic                slow_in,    // Two-pass instructions
  input  wire logic                ret_in,     // Ask for a return
  input  wire irq_ctrl_pkg::core_out_t cmd_in, // Commands from block
  output irq_ctrl_pkg::core_in_t   core_out    // Core status
);
  logic [PC_W-1:0] stack; // Saved return address
  logic            pass;  // Second pass of a slow instruction
  // Quarter phases, instruction ends, pc and context updates
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_out <= '0;
      stack    <= '0;
      pass     <= 1'b0;
    end else begin
      core_out.phase     <= core_out.phase + 2'h1;
      core_out.ctx       <= $urandom;
      core_out.instr_end <= (core_out.phase == 2'h2) && (!slow_in || pass);
      // Return in the retire phase, on either pass of a slow instruction
      core_out.return_from_irq_instruction    <= ret_in && (core_out.phase == 2'h2);
      if (core_out.phase == 2'h3) pass <= !pass;
      if (cmd_in.push) stack <= cmd_in.push_pc;
      if (cmd_in.load_pc) begin
        core_out.pc <= cmd_in.new_pc;
      end else if (cmd_in.pop) begin
        core_out.pc <= stack;
      end else if (core_out.instr_end) begin
        core_out.pc <= core_out.pc + 16'h0001;
      end
    end
  end
endmodule // core_model

// ==== sim/interrupt_entry_exit_control_tb.sv ====
// Self-checking bench for the interrupt entry and exit control
`timescale 1ns/1ps
module interrupt_entry_exit_control_tb;
  import irq_ctrl_pkg::*;
  logic       clk_sys_in = 1'b0; // Instruction clock
  logic       rst_n_in = 1'b0;   // Reset, low
  logic [7:0] event_in = '0;     // Source events
  reg_req_t   reg_in = '0;       // Register requests
  logic [7:0] rdata_out;         // Read data
  core_in_t   core_in;           // Core status
  core_in_t   cin_q;             // Core status at the last edge
  core_out_t  core_out;          // Commands to core
  logic       irq_out;           // Interrupt level
  logic       slow = 1'b0;       // Slow instructions
  logic       ret = 1'b0;        // Return request
  logic       rd_seen = 1'b0;    // Read taken at the last edge
  logic [7:0] exp_q[$];          // Expected read data
  logic [7:0] r;                 // Random event mask
  logic [CTX_W-1:0] saved;       // Context at entry
  int fail_count = 0, n_compared = 0, n_entry = 0, n_push = 0, n_ret = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  irq_entry_exit_ctrl #(.N_SRC(8)) i_irq_entry_exit_ctrl (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .event_in(event_in),
    .reg_in(reg_in), .rdata_out(rdata_out), .core_in(core_in),
    .core_out(core_out), .irq_out(irq_out));
  core_model i_core_model (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .slow_in(slow), .ret_in(ret), .cmd_in(core_out), .core_out(core_in));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic close_out;
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Register port cycles, two edges each; event pulse, one edge then n more
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in);
    reg_in <= '0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in);
    reg_in <= '0;
    @(posedge clk_sys_in);
  endtask
  task automatic ev(input logic [7:0] m, input int n);
    event_in <= m;
    @(posedge clk_sys_in);
    event_in <= '0;
    reg_in   <= '0;
    repeat (n) @(posedge clk_sys_in);
  endtask
  // Bounded wait on a counter
  task automatic await(ref int c, input int v);
    for (int k = 0; k < 80 && c < v; k++) @(posedge clk_sys_in);
    chk(c, v);
  endtask
  // Samples of what was taken at each edge
  always @(posedge clk_sys_in) begin
    rd_seen <= reg_in.rd;
    cin_q   <= core_in;
  end
  // Watcher: oldest note against each result
  always @(negedge clk_sys_in) begin
    if (rd_seen) chk(rdata_out, exp_q.pop_front());
    else chk(rdata_out, 8'h00);
    if (core_out.flush) begin
      n_entry++;
      chk(cin_q.phase, PHASE_Q1);
      chk(irq_out, 1'b0);
    end
    if (core_out.push) begin
      n_push++;
      saved = cin_q.ctx;
      chk(core_out.push_pc, cin_q.pc);
      chk(core_out.shadow, cin_q.ctx);
      chk({core_out.load_pc, core_out.new_pc}, {1'b1, IRQ_VECTOR});
    end
    if (core_out.pop) begin
      n_ret++;
      chk(core_out.restore, 1'b1);
      chk(core_out.shadow, saved);
    end
  end
  // Watchdog
  initial begin
    #100000;
    fail_count++;
    close_out();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h0c68a493));
    repeat (3) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    rd(OFS_CONTROL, 8'h00);
    rd(OFS_ENABLE, RST_ENABLE);
    rd(OFS_GROUPMAP, RST_GROUPMAP);
    rd(OFS_STATE, 8'h01);
    rd(4'hf, 8'h00);
    r = 8'($urandom) | 8'h01;
    ev(r, 0);
    rd(OFS_FLAGS, r);
    wr(OFS_CLEAR, r);
    wr(OFS_FLAGS, 8'hff);
    rd(OFS_FLAGS, 8'h00);
    wr(OFS_CONTROL, 8'h80);
    wr(OFS_ENABLE, 8'h02);
    ev(8'h03, 12);
    chk(n_entry, 0);
    wr(OFS_CONTROL, 8'hc0);
    await(n_push, 1);
    rd(OFS_CONTROL, 8'h40);
    wr(OFS_ENABLE, 8'h07);
    ev(8'h04, 12);
    chk(n_entry, 1);
    rd(OFS_FLAGS, 8'h07);
    wr(OFS_CLEAR, 8'h07);
    rd(OFS_FLAGS, 8'h00);
    ret <= 1'b1;
    await(n_ret, 1);
    ret <= 1'b0;
    rd(OFS_CONTROL, 8'hc0);
    wr(OFS_CONTROL, 8'h40);
    slow <= 1'b1;
    ev(8'h01, 12);
    chk(n_entry, 1);
    wr(OFS_CONTROL, 8'hc0);
    await(n_push, 2);
    wr(OFS_CLEAR, 8'h01);
    ret <= 1'b1;
    await(n_ret, 2);
    ret <= 1'b0;
    ev(8'h00, 4);
    wr(OFS_GROUPMAP, 8'h5a);
    rd(OFS_GROUPMAP, 8'h5a);
    close_out();
  end
endmodule // interrupt_entry_exit_control_tb
